/* logic/cfg_loader_pkg.sv */
// Shared constants of the three-wire configuration loader
`default_nettype none
package cfg_loader_pkg;
   // Serial word layout
   localparam int WORD_W = 32;
   localparam int CODE_W = 4;
   localparam int PAY_W  = WORD_W - CODE_W;
   // Register file shape
   localparam int NREG_DEF = 13;
   localparam int NREG_MAX = 16;
   // Registers whose active copy waits for a register zero write
   localparam logic [12:0] DBUF_DEF = 13'h0016;
   localparam logic [27:0] CFG_RST  = 28'h0000000;
   // Control word and its fields (full-word bit positions)
   localparam logic [3:0] CTRL_REG   = 4'h4;
   localparam int         CP_TRI_BIT = 4;
   localparam int         PD_BIT     = 5;
   localparam int         MUTE_BIT   = 10;
   localparam int         MUX_LSB    = 27;
   localparam int         MUX_W      = 3;
   // Monitor selections
   localparam logic [2:0] MUX_DLOCK = 3'h1;
   localparam logic [2:0] MUX_ALOCK = 3'h2;
   localparam logic [2:0] MUX_RFDIV = 3'h3;
   localparam logic [2:0] MUX_REFDV = 3'h4;
   // Load strobe sampling
   localparam int LE_MIN_NS   = 20;
   localparam int CORE_MHZ    = 50;
   localparam int LE_MIN_CYC  = 3;
endpackage
`default_nettype wire

/* logic/three_wire_config_loader.sv */
// Three-wire configuration port, register file and power/mute/monitor control
`default_nettype none
module three_wire_config_loader #(
   parameter int          NREG = cfg_loader_pkg::NREG_DEF,
   parameter logic [12:0] DBUF = cfg_loader_pkg::DBUF_DEF
) (
   // Core clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   // Three-wire serial port
   input  wire logic                       ser_clk,
   input  wire logic                       ser_data,
   input  wire logic                       load_strobe,
   // Control pins
   input  wire logic                       chip_en,
   input  wire logic                       rf_mute_n_pin,
   // Internal signals offered to the monitor
   input  wire logic                       dig_lock,
   input  wire logic                       ana_lock,
   input  wire logic                       rf_scaled,
   input  wire logic                       ref_scaled,
   // Active configuration
   output var  logic [NREG-1:0][27:0]      cfg_active_r,
   output var  logic                       cfg_update_r,
   // Power and output control
   output var  logic                       core_on_r,
   output var  logic                       pump_output_oe_n_r,
   output var  logic                       rf_on_r,
   output var  logic                       monitor_select_output_r
);

   localparam int PW = cfg_loader_pkg::PAY_W;
   localparam int CW = cfg_loader_pkg::CODE_W;
   localparam int WW = cfg_loader_pkg::WORD_W;

   // Elaboration checks
   generate
      if (NREG < 1 || NREG > 13) begin : g_bad_nreg
         $error("NREG must lie between 1 and 13");
      end
      if (DBUF[0]) begin : g_bad_dbuf
         $error("register zero cannot be double buffered");
      end
      if (PW != 28) begin : g_bad_width
         $error("payload width must be 28");
      end
      // Register hit and code_ok compare against 4-bit codes
      if (CW != 4) begin : g_bad_code
         $error("select code must be 4 bits");
      end
      // mux_sel is a fixed 3-bit net, so the field must match it
      if (cfg_loader_pkg::MUX_W != 3) begin : g_bad_mux_w
         $error("monitor select field must be 3 bits");
      end
      if (cfg_loader_pkg::MUX_LSB + cfg_loader_pkg::MUX_W > WW) begin : g_bad_mux_pos
         $error("monitor select field lies outside the word");
      end
      // A control bit inside the code would change with every register picked
      if (cfg_loader_pkg::CP_TRI_BIT < CW || cfg_loader_pkg::CP_TRI_BIT >= WW) begin : g_bad_tri
         $error("pump tri-state bit lies outside the payload");
      end
      if (cfg_loader_pkg::PD_BIT < CW || cfg_loader_pkg::PD_BIT >= WW) begin : g_bad_pd
         $error("power-down bit lies outside the payload");
      end
      if (cfg_loader_pkg::MUTE_BIT < CW || cfg_loader_pkg::MUTE_BIT >= WW) begin : g_bad_mute
         $error("mute bit lies outside the payload");
      end
   endgenerate

   // Decoded code is a valid register number
   function automatic logic code_ok(input logic [3:0] c);
      code_ok = (int'(c) < NREG);
   endfunction

   // Picks one full-word bit of the control register
   function automatic logic ctrl_bit(input logic [31:0] w, input int pos);
      ctrl_bit = w[pos];
   endfunction

   // ---------------------------------------------------------------
   // Link domain: runs only while the host clocks it
   // ---------------------------------------------------------------
   logic [WW-1:0] shift_r;
   logic [WW-1:0] shift_nxt;

   // Newest bit enters at bit zero, so the first bit sent ends at the top
   assign shift_nxt = {shift_r[WW-2:0], ser_data};

   // No reset: contents matter only when the strobe samples them
   always_ff @(posedge ser_clk) begin
      shift_r <= shift_nxt;
   end

   // ---------------------------------------------------------------
   // Core domain: pin synchronisers
   // ---------------------------------------------------------------
   logic le_s1_r;
   logic le_s2_r;
   logic le_s3_r;
   logic ce_s1_r;
   logic ce_s2_r;
   logic mn_s1_r;
   logic mn_s2_r;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         le_s1_r <= 1'b0;
         le_s2_r <= 1'b0;
         le_s3_r <= 1'b0;
      end else begin
         le_s1_r <= load_strobe;
         le_s2_r <= le_s1_r;
         le_s3_r <= le_s2_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ce_s1_r <= 1'b0;
         ce_s2_r <= 1'b0;
      end else begin
         ce_s1_r <= chip_en;
         ce_s2_r <= ce_s1_r;
      end
   end

   // Mute pin resets to the muted level so the RF stays quiet at start
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mn_s1_r <= 1'b0;
         mn_s2_r <= 1'b0;
      end else begin
         mn_s1_r <= rf_mute_n_pin;
         mn_s2_r <= mn_s1_r;
      end
   end

   // ---------------------------------------------------------------
   // Word capture
   // ---------------------------------------------------------------
   // The host holds the serial clock still while the strobe is high,
   // so the shift register is quiet when this edge samples it. The
   // strobe therefore acts as the request of the crossing; a strobe
   // shorter than one core cycle may be missed.
   logic           le_rise;
   logic [CW-1:0]  code_w;
   logic [PW-1:0]  pay_w;
   logic           load_ok;
   logic           reg0_hit;

   assign le_rise  = le_s2_r & ~le_s3_r;
   assign code_w   = shift_r[CW-1:0];
   assign pay_w    = shift_r[WW-1:CW];
   assign load_ok  = le_rise & code_ok(code_w);
   assign reg0_hit = load_ok & (code_w == 4'h0);

   // ---------------------------------------------------------------
   // Register file: staged copy and active copy
   // ---------------------------------------------------------------
   logic [NREG-1:0][PW-1:0] stage_r;
   logic [NREG-1:0][PW-1:0] stage_nxt;
   logic [NREG-1:0][PW-1:0] act_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         wire hit_w = load_ok & (code_w == 4'(gi));
         wire buf_w = DBUF[gi];
         // Staged copy always follows the latest write
         assign stage_nxt[gi] = hit_w ? pay_w : stage_r[gi];
         // Buffered entries move on a register zero write only
         assign act_nxt[gi] =
            (hit_w & ~buf_w)    ? pay_w :
            (reg0_hit & buf_w)  ? stage_r[gi] :
            cfg_active_r[gi];
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stage_r <= {NREG{cfg_loader_pkg::CFG_RST}};
      end else begin
         stage_r <= stage_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_active_r <= {NREG{cfg_loader_pkg::CFG_RST}};
      end else begin
         cfg_active_r <= act_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_update_r <= 1'b0;
      end else begin
         cfg_update_r <= load_ok;
      end
   end

   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   // Controls read the staged copy, so power, mute and monitor act at
   // once even when their register carries buffered divider values.
   logic [WW-1:0]  ctrl_w;
   logic           sw_pd;
   logic           sw_cp_tri;
   logic           sw_mute;
   logic [2:0]     mux_sel;

   generate
      if (int'(cfg_loader_pkg::CTRL_REG) < NREG) begin : g_ctrl
         assign ctrl_w = {stage_r[cfg_loader_pkg::CTRL_REG], cfg_loader_pkg::CTRL_REG};
      end else begin : g_noctrl
         assign ctrl_w = {cfg_loader_pkg::CFG_RST, cfg_loader_pkg::CTRL_REG};
      end
   endgenerate

   assign sw_pd     = ctrl_bit(ctrl_w, cfg_loader_pkg::PD_BIT);
   assign sw_cp_tri = ctrl_bit(ctrl_w, cfg_loader_pkg::CP_TRI_BIT);
   assign sw_mute   = ctrl_bit(ctrl_w, cfg_loader_pkg::MUTE_BIT);
   assign mux_sel   = ctrl_w[cfg_loader_pkg::MUX_LSB +: cfg_loader_pkg::MUX_W];

   // ---------------------------------------------------------------
   // Power, pump, mute
   // ---------------------------------------------------------------
   logic core_nxt;
   logic pump_on;
   logic rf_nxt;

   assign core_nxt = ce_s2_r & ~sw_pd;
   assign pump_on  = core_nxt & ~sw_cp_tri;
   assign rf_nxt   = core_nxt & mn_s2_r & ~sw_mute;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         core_on_r <= 1'b0;
      end else begin
         core_on_r <= core_nxt;
      end
   end

   // Enable is low while the pump drives; high means floating
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pump_output_oe_n_r <= 1'b1;
      end else begin
         pump_output_oe_n_r <= ~pump_on;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rf_on_r <= 1'b0;
      end else begin
         rf_on_r <= rf_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Monitor output
   // ---------------------------------------------------------------
   logic is_dlock;
   logic is_alock;
   logic is_rfdiv;
   logic is_refdv;
   logic mon_w;

   assign is_dlock = (mux_sel == cfg_loader_pkg::MUX_DLOCK);
   assign is_alock = (mux_sel == cfg_loader_pkg::MUX_ALOCK);
   assign is_rfdiv = (mux_sel == cfg_loader_pkg::MUX_RFDIV);
   assign is_refdv = (mux_sel == cfg_loader_pkg::MUX_REFDV);

   // Unused codes and power-down give a steady low
   assign mon_w = core_nxt & ((is_dlock & dig_lock)
                            | (is_alock & ana_lock)
                            | (is_rfdiv & rf_scaled)
                            | (is_refdv & ref_scaled));

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         monitor_select_output_r <= 1'b0;
      end else begin
         monitor_select_output_r <= mon_w;
      end
   end

endmodule
`default_nettype wire

/* verif/cfg_host_model.sv */
// Host side of the three-wire port: serial clock, data and load strobe
`default_nettype none
module cfg_host_model (
   // Serial port toward the device
   output var logic ser_clk,
   output var logic ser_data,
   output var logic load_strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      load_strobe = 1'b0;
   end
   // Clock stands still between frames; idle data flips so stale bits show
   task automatic send(input logic [31:0] w, input logic le);
      for (int i = 31; i >= 0; i--) begin
         ser_data = w[i];
         #3 ser_clk = 1'b1;
         #6 ser_clk = 1'b0;
         #3;
      end
      ser_data = ~w[0];
      #20 load_strobe = le;
      #100 load_strobe = 1'b0;
      #60;
   endtask
endmodule
`default_nettype wire

/* verif/test_three_wire_config_loader.sv */
// Self-checking bench of the three-wire configuration loader
`default_nettype none
module test_three_wire_config_loader;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic chip_en = 1'b0;
   logic rf_mute_n_pin = 1'b0;
   logic [3:0] src = 4'h0;
   wire logic ser_clk, ser_data, load_strobe;
   wire logic [12:0][27:0] cfg_active_r;
   wire logic cfg_update_r, core_on_r, pump_output_oe_n_r, rf_on_r, monitor_select_output_r;
   logic [27:0] stg [13] = '{default: 28'h0};
   logic [27:0] act [13] = '{default: 28'h0};
   logic [31:0] ctl = 32'h0;
   logic [31:0] rnd = 32'h175E;
   int failures = 0;
   int checked = 0;
   int pulses = 0;
   int want = 0;
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) if (cfg_update_r === 1'b1) pulses <= pulses + 1;
   cfg_host_model host (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));
   three_wire_config_loader uut (
      .core_clk(core_clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data),
      .load_strobe(load_strobe), .chip_en(chip_en), .rf_mute_n_pin(rf_mute_n_pin),
      .dig_lock(src[0]), .ana_lock(src[1]), .rf_scaled(src[2]), .ref_scaled(src[3]),
      .cfg_active_r(cfg_active_r), .cfg_update_r(cfg_update_r), .core_on_r(core_on_r),
      .pump_output_oe_n_r(pump_output_oe_n_r), .rf_on_r(rf_on_r),
      .monitor_select_output_r(monitor_select_output_r));
   function automatic logic [31:0] lfsr(input logic [31:0] r);
      return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // Pins need three core edges, so five leaves margin
   task automatic settle();
      logic on;
      repeat (5) @(posedge core_clk);
      #1;
      on = chip_en & ~ctl[cfg_loader_pkg::PD_BIT];
      chk("update count", want, pulses);
      for (int i = 0; i < 13; i++) chk("active reg", act[i], cfg_active_r[i]);
      chk("core on", on, core_on_r);
      chk("pump oe_n", !(on && !ctl[cfg_loader_pkg::CP_TRI_BIT]), pump_output_oe_n_r);
      chk("rf on", on & rf_mute_n_pin & ~ctl[cfg_loader_pkg::MUTE_BIT], rf_on_r);
   endtask
   task automatic put(input logic [3:0] c, input logic [27:0] p);
      host.send({p, c}, 1'b1);
      if (c < 4'hD) begin
         want++;
         stg[c] = p;
         if (!cfg_loader_pkg::DBUF_DEF[c]) act[c] = p;
         if (c == 4'h0) for (int i = 1; i < 13; i++) if (cfg_loader_pkg::DBUF_DEF[i]) act[i] = stg[i];
         if (c == cfg_loader_pkg::CTRL_REG) ctl = {p, c};
      end
      settle();
   endtask
   task automatic mux(input logic [2:0] m);
      logic e;
      put(cfg_loader_pkg::CTRL_REG, {2'h0, m, 23'h0});
      repeat (6) begin
         src = rnd[3:0];
         rnd = lfsr(rnd);
         @(posedge core_clk);
         #1;
         e = (m == 3'h1) ? src[0] : (m == 3'h2) ? src[1] : (m == 3'h3) ? src[2] :
             (m == 3'h4) ? src[3] : 1'b0;
         chk("monitor", e, monitor_select_output_r);
      end
   endtask
   task automatic test_done();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      chk("pump oe_n reset", 1'b1, pump_output_oe_n_r);
      chip_en = 1'b1;
      rf_mute_n_pin = 1'b1;
      for (int m = 0; m < 8; m++) mux(m[2:0]);
      for (int k = 0; k < 32; k++) begin
         put(k[3:0], rnd[27:0]);
         rnd = lfsr(rnd);
      end
      host.send(rnd, 1'b0);
      settle();
      src = 4'hF;
      put(cfg_loader_pkg::CTRL_REG, 28'h0800002);
      chk("monitor off", 1'b0, monitor_select_output_r);
      put(cfg_loader_pkg::CTRL_REG, 28'h0800001);
      chk("monitor on", 1'b1, monitor_select_output_r);
      put(cfg_loader_pkg::CTRL_REG, 28'h0000040);
      put(cfg_loader_pkg::CTRL_REG, 28'h0000000);
      rf_mute_n_pin = 1'b0;
      settle();
      chip_en = 1'b0;
      settle();
      test_done();
   end
   initial begin
      #300000;
      failures++;
      test_done();
   end
endmodule
`default_nettype wire

/* verif/three_wire_config_loader_checker.sv */
// Port assertions of the configuration loader
`default_nettype none
module three_wire_config_loader_checker #(
   parameter int NREG = cfg_loader_pkg::NREG_DEF
) (
   // Watched ports
   input wire logic                  core_clk,
   input wire logic                  sys_rst,
   input wire logic                  load_strobe,
   input wire logic                  chip_en,
   input wire logic                  rf_mute_n_pin,
   input wire logic [NREG-1:0][27:0] cfg_active_r,
   input wire logic                  cfg_update_r,
   input wire logic                  core_on_r,
   input wire logic                  pump_output_oe_n_r,
   input wire logic                  rf_on_r,
   input wire logic                  monitor_select_output_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_update_gap: assert property (cfg_update_r |=> !cfg_update_r [*8])
      else $error("update pulse repeated too soon");
   a_update_strobe: assert property ($rose(cfg_update_r) |-> $past(load_strobe, 2))
      else $error("update without load strobe");
   a_active_quiet: assert property ($changed(cfg_active_r) |-> cfg_update_r)
      else $error("register changed without update");
   a_pump_off: assert property (!core_on_r |-> pump_output_oe_n_r)
      else $error("pump driven while powered down");
   a_ce_down: assert property (!chip_en [*4] |-> !core_on_r)
      else $error("core on with chip enable low");
   a_rf_core: assert property (rf_on_r |-> core_on_r)
      else $error("rf on while core off");
   a_rf_pin: assert property (!rf_mute_n_pin [*4] |-> !rf_on_r)
      else $error("rf on while mute pin low");
   a_mon_off: assert property (!core_on_r && $past(!core_on_r) |-> !monitor_select_output_r)
      else $error("monitor active while powered down");
endmodule
bind three_wire_config_loader three_wire_config_loader_checker #(.NREG(NREG)) chk_i (
   .core_clk, .sys_rst, .load_strobe, .chip_en, .rf_mute_n_pin, .cfg_active_r,
   .cfg_update_r, .core_on_r, .pump_output_oe_n_r, .rf_on_r, .monitor_select_output_r);
`default_nettype wire
